// ---- design/cia_pkg.sv ----
// package: constants for the cpu control and 16-bit arithmetic block
// assumes: single clock, opcodes fed one byte per machine cycle
package cia_pkg;
    localparam logic [7:0]  OP_IDLE    = 8'h00;
    localparam logic [7:0]  OP_HALT    = 8'h76;
    localparam logic [7:0]  OP_DIS     = 8'hF3;
    localparam logic [7:0]  OP_ENA     = 8'hFB;
    localparam logic [7:0]  PFX_ED     = 8'hED;
    localparam logic [7:0]  PFX_DD     = 8'hDD;
    localparam logic [7:0]  OP_MODE0   = 8'h46;
    localparam logic [7:0]  OP_MODE1   = 8'h56;
    localparam logic [7:0]  OP_MODE2   = 8'h5E;
    localparam logic [7:0]  MASK_PAIR  = 8'hCF;
    localparam logic [7:0]  OP_ADD16   = 8'h09;
    localparam logic [7:0]  OP_ADC16   = 8'h4A;
    localparam logic [7:0]  OP_SWB16   = 8'h42;
    localparam logic [15:0] RST_VECTOR = 16'h0038;
    localparam logic [1:0]  SEL_FIRST  = 2'b00;
    localparam logic [1:0]  SEL_SECOND = 2'b01;
    localparam logic [1:0]  SEL_MAIN   = 2'b10;
    localparam logic [1:0]  SEL_STACK  = 2'b11;
    localparam int          T_PER_M    = 4;
    localparam logic [1:0]  T_LAST     = 2'(T_PER_M - 1);
    localparam int          FLG_C      = 0;
    localparam int          FLG_N      = 1;
    localparam int          FLG_PV     = 2;
    localparam int          FLG_H      = 4;
    localparam int          FLG_Z      = 6;
    localparam int          FLG_S      = 7;
    localparam logic [7:0]  FLAGS_RST  = 8'h00;
    localparam logic [15:0] PAIR_RST   = 16'h0000;
    typedef enum logic [1:0] {
        MODE_ZERO = 2'b00,
        MODE_ONE  = 2'b01,
        MODE_TWO  = 2'b10
    } cia_mode_t;
    typedef enum logic [1:0] {
        ST_FETCH = 2'b00,
        ST_ED    = 2'b01,
        ST_DD    = 2'b10,
        ST_HALT  = 2'b11
    } cia_state_t;
endpackage : cia_pkg

// ---- design/cia_core.sv ----
// module: decode/execute of cpu control and 16-bit add group
// assumes: opcode byte on I_OPCODE sampled at the last t state of each
// machine cycle; I_IRQ_B comes from outside the clock domain
// Function
// - opcode 00 does nothing, flags kept, one 4-state cycle
// - opcode 76 halts until interrupt or reset, flags kept
// - halted core keeps issuing idle cycles for refresh
// - opcode F3 clears both enable flops in one 4-state cycle
// - with enables cleared the request pin is ignored
// - opcode FB sets both enable flops
// - no acceptance during FB nor the instruction after it
// - ED 46 picks mode zero; device supplies instruction bytes
// - ED 56 picks mode one; restart to 0038h
// - ED 5E picks mode two; vector forms pointer low byte
// - mode two reads table entry then calls indirectly
// - add selected pair to main pair; selector 00,01,10,11
// - plain 16-bit add keeps S Z PV, H C from result, clears N
// - ED add-with-carry: main plus pair plus carry
// - adc flags: S Z H PV C from result, N cleared
// - ED subtract-with-borrow: main minus pair minus carry
// - borrow-subtract flags: S Z, H borrow bit 12, PV, C, N set
// - DD add to first index; code 10 means index itself
`timescale 1ns/1ps
module cia_core (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST_B,
    input  wire logic [7:0]  I_OPCODE,
    input  wire logic        I_IRQ_B,
    input  wire logic [7:0]  I_VECTOR,
    input  wire logic [7:0]  I_VEC_BASE,
    input  wire logic [15:0] I_FIRST_PAIR,
    input  wire logic [15:0] I_SECOND_PAIR,
    input  wire logic [15:0] I_STACK_PTR,
    output logic [15:0]      O_MAIN_PAIR,
    output logic [15:0]      O_INDEX_REG,
    output logic [7:0]       O_FLAGS,
    output logic             O_IRQ_ENABLE_A,
    output logic             O_IRQ_ENABLE_B,
    output logic [1:0]       O_IRQ_MODE,
    output logic             O_HALTED,
    output logic             O_M1_END,
    output logic             O_IRQ_ACK,
    output logic [15:0]      O_IRQ_TARGET,
    output logic             O_TABLE_READ
);
    ////////////////////////////////////////////////////////////////////
    // registers
    logic [1:0]            t_cnt_ff;
    cia_pkg::cia_state_t   state_ff;
    logic [15:0]           main_pair_ff;
    logic [15:0]           first_index_register_ff;
    logic [7:0]            flags_ff;
    logic                  irq_enable_flop_a_ff;
    logic                  irq_enable_flop_b_ff;
    logic                  ena_delay_ff;
    logic [1:0]            mode_ff;
    logic                  m1_end_ff;
    logic                  ack_ff;
    logic [15:0]           target_ff;
    logic                  table_rd_ff;
    logic [1:0]            irq_sync_ff;
    logic                  halted_ff;

    ////////////////////////////////////////////////////////////////////
    // decode
    function automatic logic [15:0] pick_pair(input logic [1:0] sel,
                                              input logic [15:0] own,
                                              input logic [15:0] p1,
                                              input logic [15:0] p2,
                                              input logic [15:0] sp);
        unique case (sel)
            cia_pkg::SEL_FIRST:  pick_pair = p1;
            cia_pkg::SEL_SECOND: pick_pair = p2;
            cia_pkg::SEL_MAIN:   pick_pair = own;
            cia_pkg::SEL_STACK:  pick_pair = sp;
        endcase
    endfunction : pick_pair

    wire        m_end    = (t_cnt_ff == cia_pkg::T_LAST);
    wire        irq_req  = ~irq_sync_ff[1];
    wire [1:0]  index_pair_selector = I_OPCODE[5:4];
    wire        is_pair_op = (I_OPCODE & cia_pkg::MASK_PAIR)
                           == cia_pkg::OP_ADD16;
    wire        is_adc   = (I_OPCODE & cia_pkg::MASK_PAIR)
                           == cia_pkg::OP_ADC16;
    wire        is_swb   = (I_OPCODE & cia_pkg::MASK_PAIR)
                           == cia_pkg::OP_SWB16;
    wire [15:0] opnd_main = pick_pair(index_pair_selector, main_pair_ff,
                          I_FIRST_PAIR, I_SECOND_PAIR, I_STACK_PTR);
    wire [15:0] opnd_idx  = pick_pair(index_pair_selector,
                          first_index_register_ff, I_FIRST_PAIR,
                          I_SECOND_PAIR, I_STACK_PTR);
    wire        carry_flag = flags_ff[cia_pkg::FLG_C];
    wire [16:0] add_main = {1'b0, main_pair_ff} + {1'b0, opnd_main};
    wire [12:0] add_main_lo = {1'b0, main_pair_ff[11:0]}
                            + {1'b0, opnd_main[11:0]};
    wire [16:0] add_idx  = {1'b0, first_index_register_ff}
                         + {1'b0, opnd_idx};
    wire [12:0] add_idx_lo = {1'b0, first_index_register_ff[11:0]}
                           + {1'b0, opnd_idx[11:0]};
    wire [16:0] adc_sum  = add_main + {16'h0000, carry_flag};
    wire [12:0] adc_lo   = add_main_lo + {12'h000, carry_flag};
    wire [16:0] swb_dif  = {1'b0, main_pair_ff} - {1'b0, opnd_main}
                         - {16'h0000, carry_flag};
    wire [12:0] swb_lo   = {1'b0, main_pair_ff[11:0]}
                         - {1'b0, opnd_main[11:0]}
                         - {12'h000, carry_flag};
    wire        adc_ovf  = (main_pair_ff[15] == opnd_main[15])
                         && (adc_sum[15] != main_pair_ff[15]);
    wire        swb_ovf  = (main_pair_ff[15] != opnd_main[15])
                         && (swb_dif[15] != main_pair_ff[15]);
    // accept only at boundary, flop a set, no enable delay
    wire        irq_take = m_end && irq_req && irq_enable_flop_a_ff
                         && !ena_delay_ff
                         && (state_ff inside {cia_pkg::ST_FETCH,
                                              cia_pkg::ST_HALT});

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    cia_pkg::cia_state_t nxt_state;
    logic [15:0] nxt_main;
    logic [15:0] nxt_index;
    logic [7:0]  nxt_flags;
    logic        nxt_en_a;
    logic        nxt_en_b;
    logic        nxt_delay;
    logic [1:0]  nxt_mode;

    always_comb begin
        nxt_state = state_ff;
        nxt_main  = main_pair_ff;
        nxt_index = first_index_register_ff;
        nxt_flags = flags_ff;
        nxt_en_a  = irq_enable_flop_a_ff;
        nxt_en_b  = irq_enable_flop_b_ff;
        nxt_delay = ena_delay_ff;
        nxt_mode  = mode_ff;
        if (m_end) begin
            // the delay lasts through the instruction after enable
            if (state_ff == cia_pkg::ST_FETCH) begin
                nxt_delay = 1'b0;
            end
            if (irq_take) begin
                nxt_state = cia_pkg::ST_FETCH;
                nxt_en_a  = 1'b0;
                nxt_en_b  = 1'b0;
            end else begin
                unique case (state_ff)
                    cia_pkg::ST_FETCH: begin
                        if (I_OPCODE == cia_pkg::OP_HALT) begin
                            nxt_state = cia_pkg::ST_HALT;
                        end else if (I_OPCODE == cia_pkg::OP_DIS) begin
                            nxt_en_a = 1'b0;
                            nxt_en_b = 1'b0;
                        end else if (I_OPCODE == cia_pkg::OP_ENA) begin
                            nxt_en_a  = 1'b1;
                            nxt_en_b  = 1'b1;
                            nxt_delay = 1'b1;
                        end else if (I_OPCODE == cia_pkg::PFX_ED) begin
                            nxt_state = cia_pkg::ST_ED;
                        end else if (I_OPCODE == cia_pkg::PFX_DD) begin
                            nxt_state = cia_pkg::ST_DD;
                        end else if (is_pair_op) begin
                            nxt_main = add_main[15:0];
                            nxt_flags[cia_pkg::FLG_H] = add_main_lo[12];
                            nxt_flags[cia_pkg::FLG_C] = add_main[16];
                            nxt_flags[cia_pkg::FLG_N] = 1'b0;
                        end
                        // opcode 00 and the rest change nothing
                    end
                    cia_pkg::ST_ED: begin
                        nxt_state = cia_pkg::ST_FETCH;
                        if (I_OPCODE == cia_pkg::OP_MODE0) begin
                            nxt_mode = cia_pkg::MODE_ZERO;
                        end else if (I_OPCODE == cia_pkg::OP_MODE1) begin
                            nxt_mode = cia_pkg::MODE_ONE;
                        end else if (I_OPCODE == cia_pkg::OP_MODE2) begin
                            nxt_mode = cia_pkg::MODE_TWO;
                        end else if (is_adc) begin
                            nxt_main = adc_sum[15:0];
                            nxt_flags[cia_pkg::FLG_S]  = adc_sum[15];
                            nxt_flags[cia_pkg::FLG_Z]  =
                                (adc_sum[15:0] == 16'h0000);
                            nxt_flags[cia_pkg::FLG_H]  = adc_lo[12];
                            nxt_flags[cia_pkg::FLG_PV] = adc_ovf;
                            nxt_flags[cia_pkg::FLG_C]  = adc_sum[16];
                            nxt_flags[cia_pkg::FLG_N]  = 1'b0;
                        end else if (is_swb) begin
                            nxt_main = swb_dif[15:0];
                            nxt_flags[cia_pkg::FLG_S]  = swb_dif[15];
                            nxt_flags[cia_pkg::FLG_Z]  =
                                (swb_dif[15:0] == 16'h0000);
                            nxt_flags[cia_pkg::FLG_H]  = swb_lo[12];
                            nxt_flags[cia_pkg::FLG_PV] = swb_ovf;
                            nxt_flags[cia_pkg::FLG_C]  = swb_dif[16];
                            nxt_flags[cia_pkg::FLG_N]  = 1'b1;
                        end
                    end
                    cia_pkg::ST_DD: begin
                        nxt_state = cia_pkg::ST_FETCH;
                        if (is_pair_op) begin
                            nxt_index = add_idx[15:0];
                            nxt_flags[cia_pkg::FLG_H] = add_idx_lo[12];
                            nxt_flags[cia_pkg::FLG_C] = add_idx[16];
                            nxt_flags[cia_pkg::FLG_N] = 1'b0;
                        end
                    end
                    cia_pkg::ST_HALT: begin
                        nxt_state = cia_pkg::ST_HALT;
                    end
                endcase
            end
        end
    end

    // interrupt target per mode; mode zero takes the device byte
    logic [15:0] nxt_target;
    always_comb begin
        unique case (mode_ff)
            cia_pkg::MODE_ONE: nxt_target = cia_pkg::RST_VECTOR;
            cia_pkg::MODE_TWO: nxt_target = {I_VEC_BASE, I_VECTOR};
            default:           nxt_target = {8'h00, I_VECTOR};
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // flip-flops
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            irq_sync_ff <= 2'b11;
        end else begin
            irq_sync_ff <= {irq_sync_ff[0], I_IRQ_B};
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            t_cnt_ff                <= 2'b00;
            state_ff                <= cia_pkg::ST_FETCH;
            main_pair_ff            <= cia_pkg::PAIR_RST;
            first_index_register_ff <= cia_pkg::PAIR_RST;
            flags_ff                <= cia_pkg::FLAGS_RST;
            irq_enable_flop_a_ff    <= 1'b0;
            irq_enable_flop_b_ff    <= 1'b0;
            ena_delay_ff            <= 1'b0;
            mode_ff                 <= cia_pkg::MODE_ZERO;
        end else begin
            t_cnt_ff                <= t_cnt_ff + 2'b01;
            state_ff                <= nxt_state;
            main_pair_ff            <= nxt_main;
            first_index_register_ff <= nxt_index;
            flags_ff                <= nxt_flags;
            irq_enable_flop_a_ff    <= nxt_en_a;
            irq_enable_flop_b_ff    <= nxt_en_b;
            ena_delay_ff            <= nxt_delay;
            mode_ff                 <= nxt_mode;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            m1_end_ff   <= 1'b0;
            ack_ff      <= 1'b0;
            target_ff   <= cia_pkg::PAIR_RST;
            table_rd_ff <= 1'b0;
            halted_ff   <= 1'b0;
        end else begin
            m1_end_ff   <= m_end;
            ack_ff      <= irq_take;
            halted_ff   <= (nxt_state == cia_pkg::ST_HALT);
            table_rd_ff <= irq_take
                           && (mode_ff == cia_pkg::MODE_TWO);
            if (irq_take) begin
                target_ff <= nxt_target;
            end
        end
    end

    assign O_MAIN_PAIR    = main_pair_ff;
    assign O_INDEX_REG    = first_index_register_ff;
    assign O_FLAGS        = flags_ff;
    assign O_IRQ_ENABLE_A = irq_enable_flop_a_ff;
    assign O_IRQ_ENABLE_B = irq_enable_flop_b_ff;
    assign O_IRQ_MODE     = mode_ff;
    assign O_HALTED       = halted_ff;
    assign O_M1_END       = m1_end_ff;
    assign O_IRQ_ACK      = ack_ff;
    assign O_IRQ_TARGET   = target_ff;
    assign O_TABLE_READ   = table_rd_ff;

    ////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);

    cycle_four_a: assert property (m_end |=> !m_end [*3] ##1 m_end)
        else $error("machine cycle not four states");
    dis_clears_a: assert property (m_end && state_ff == cia_pkg::ST_FETCH
        && I_OPCODE == cia_pkg::OP_DIS && !irq_take
        |=> !irq_enable_flop_a_ff && !irq_enable_flop_b_ff)
        else $error("disable left an enable set");
    ena_sets_a: assert property (m_end && state_ff == cia_pkg::ST_FETCH
        && I_OPCODE == cia_pkg::OP_ENA && !irq_take
        |=> irq_enable_flop_a_ff && irq_enable_flop_b_ff)
        else $error("enable did not set both flops");
    no_take_off_a: assert property (!irq_enable_flop_a_ff |=> !ack_ff)
        else $error("interrupt taken while disabled");
    ena_delay_a: assert property (ena_delay_ff |=> !ack_ff)
        else $error("interrupt taken in enable shadow");
    halt_hold_a: assert property (O_HALTED && !irq_take |=> O_HALTED)
        else $error("halt left without interrupt");
    idle_flags_a: assert property (m_end && state_ff == cia_pkg::ST_FETCH
        && I_OPCODE == cia_pkg::OP_IDLE |=> $stable(flags_ff))
        else $error("no-op changed flags");
    mode_one_a: assert property (irq_take && mode_ff == cia_pkg::MODE_ONE
        |=> target_ff == cia_pkg::RST_VECTOR)
        else $error("mode one target wrong");
    mode_two_a: assert property (irq_take && mode_ff == cia_pkg::MODE_TWO
        |=> table_rd_ff && target_ff[15:8] == $past(I_VEC_BASE))
        else $error("mode two pointer wrong");
    swb_nflag_a: assert property (m_end && state_ff == cia_pkg::ST_ED
        && is_swb && !irq_take |=> flags_ff[cia_pkg::FLG_N])
        else $error("subtract flag not set");

    halt_cov: cover property (O_HALTED ##[1:40] ack_ff);
    ena_cov:  cover property (ena_delay_ff ##[1:20] ack_ff);
    swb_cov:  cover property (m_end && state_ff == cia_pkg::ST_ED && is_swb);
endmodule : cia_core

// ---- tb/cia_periph_model.sv ----
// partner model: interrupting peripheral on the system bus
// assumes: bench pulses i_raise for one cycle; request pin has a pull-up
`timescale 1ns/1ps
module cia_periph_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_raise,
    input  wire logic       i_slow,
    input  wire logic [7:0] i_vec,
    input  wire logic       i_ack,
    output logic            o_irq_b,
    output logic [7:0]      o_vector
);
    logic       pend_ff;
    logic [2:0] wait_ff;
    logic [7:0] vec_ff;

    ////////////////////////////////////////////////////////////////////////
    // request raised promptly or slowly, dropped on acknowledge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pend_ff <= 1'b0;
            wait_ff <= 3'h0;
            vec_ff  <= 8'h00;
        end else if (i_raise) begin
            vec_ff  <= i_vec;
            wait_ff <= i_slow ? 3'h5 : 3'h1;
        end else if (wait_ff == 3'h1) begin
            pend_ff <= 1'b1;
            wait_ff <= 3'h0;
        end else if (wait_ff != 3'h0) begin
            wait_ff <= wait_ff - 3'h1;
        end else if (i_ack) begin
            pend_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // released pin goes high; byte is valid only while requesting
    assign o_irq_b  = ~pend_ff;
    assign o_vector = pend_ff ? vec_ff : ~vec_ff;
endmodule : cia_periph_model

// ---- tb/cia_core_tb_top.sv ----
// testbench: drives opcodes and requests into the decode/execute core
// assumes: one opcode per machine cycle, inputs changed on falling edge
`timescale 1ns/1ps
module cia_core_tb_top;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [7:0]  vec_base = 8'hA5;
    logic [15:0] first_p = 16'h8000;
    logic [15:0] second_p = 16'h7FFF;
    logic [15:0] stack_p = 16'hF00F;
    logic        raise = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  vec = 8'h00;
    wire         irq_b, en_a, en_b, halted, m1_end, ack, tbl;
    wire  [7:0]  vector, flags;
    wire  [15:0] main_pair, index_reg, target;
    wire  [1:0]  mode;
    int          fails = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          last_m1 = 0;
    int          gap = 0;
    logic        got_ack, got_tbl;
    logic [15:0] e_main = 16'h0000;
    logic [15:0] e_idx = 16'h0000;
    logic [7:0]  e_f = 8'h00;

    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    cia_core u_dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_OPCODE(opcode),
        .I_IRQ_B(irq_b), .I_VECTOR(vector), .I_VEC_BASE(vec_base),
        .I_FIRST_PAIR(first_p), .I_SECOND_PAIR(second_p),
        .I_STACK_PTR(stack_p), .O_MAIN_PAIR(main_pair),
        .O_INDEX_REG(index_reg), .O_FLAGS(flags), .O_IRQ_ENABLE_A(en_a),
        .O_IRQ_ENABLE_B(en_b), .O_IRQ_MODE(mode), .O_HALTED(halted),
        .O_M1_END(m1_end), .O_IRQ_ACK(ack), .O_IRQ_TARGET(target),
        .O_TABLE_READ(tbl));

    cia_periph_model u_periph (.i_clk(clk), .i_rst_b(rst_b), .i_raise(raise),
        .i_slow(slow), .i_vec(vec), .i_ack(ack), .o_irq_b(irq_b),
        .o_vector(vector));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %b", $time, what, got);
        end
    endtask : chk_bit

    // one byte per machine cycle; waits for cycle end or acknowledge
    task automatic exec(input logic [7:0] op);
        int n;
        n = 0;
        got_ack = 1'b0;
        got_tbl = 1'b0;
        @(negedge clk);
        opcode = op;
        do begin
            @(negedge clk);
            n++;
            got_ack = got_ack | ack;
            got_tbl = got_tbl | tbl;
        end while (m1_end !== 1'b1 && ack !== 1'b1 && n < 12);
        if (m1_end !== 1'b1 && ack !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: machine cycle never ended", $time);
            end_sim();
        end
        gap = cyc - last_m1;
        last_m1 = cyc;
        @(negedge clk);
        got_ack = got_ack | ack;
        got_tbl = got_tbl | tbl;
    endtask : exec

    task automatic raise_irq(input logic [7:0] v, input logic s);
        vec = v;
        slow = s;
        raise = 1'b1;
        @(negedge clk);
        raise = 1'b0;
    endtask : raise_irq

    ////////////////////////////////////////////////////////////////////////
    // every selector code of every add/subtract form, model kept here
    task automatic arith_case;
        logic [15:0] a, b, r;
        logic [16:0] w;
        logic [12:0] h;
        logic [7:0]  base;
        logic        c;
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 4; s++) begin
                a = (k == 3) ? e_idx : e_main;
                b = (s == 0) ? first_p : (s == 1) ? second_p :
                    (s == 2) ? a : stack_p;
                c = (k == 1 || k == 2) ? e_f[cia_pkg::FLG_C] : 1'b0;
                w = (k == 2) ? {1'b0, a} - {1'b0, b} - 17'(c)
                             : {1'b0, a} + {1'b0, b} + 17'(c);
                h = (k == 2) ? {1'b0, a[11:0]} - {1'b0, b[11:0]} - 13'(c)
                             : {1'b0, a[11:0]} + {1'b0, b[11:0]} + 13'(c);
                r = w[15:0];
                e_f[cia_pkg::FLG_H] = h[12];
                e_f[cia_pkg::FLG_C] = w[16];
                e_f[cia_pkg::FLG_N] = (k == 2);
                if (k == 1 || k == 2) begin
                    e_f[cia_pkg::FLG_S] = r[15];
                    e_f[cia_pkg::FLG_Z] = (r == 16'h0000);
                    e_f[cia_pkg::FLG_PV] = ((a[15] ^ b[15]) == (k == 2)) &&
                                           (r[15] != a[15]);
                end
                if (k == 3)
                    e_idx = r;
                else
                    e_main = r;
                base = (k == 1) ? cia_pkg::OP_ADC16 :
                       (k == 2) ? cia_pkg::OP_SWB16 : cia_pkg::OP_ADD16;
                if (k == 1 || k == 2)
                    exec(cia_pkg::PFX_ED);
                if (k == 3)
                    exec(cia_pkg::PFX_DD);
                exec(base | 8'(s << 4));
                chk_word(main_pair, e_main, "main");
                chk_word(index_reg, e_idx, "index reg");
                chk_word(16'(flags), 16'(e_f), "flag");
            end
        end
        $display("test arith done");
    endtask : arith_case

    task automatic idle_case;
        exec(cia_pkg::OP_IDLE);
        exec(cia_pkg::OP_IDLE);
        chk_word(16'(gap), 16'h0004, "idle cycle length");
        chk_word(main_pair, e_main, "idle main pair");
        chk_word({8'h00, flags}, {8'h00, e_f}, "idle flags");
        $display("test idle done");
    endtask : idle_case

    task automatic irq_case(input logic [7:0] mop, input logic [1:0] emode,
                            input logic [7:0] v, input logic [15:0] etgt,
                            input logic etbl);
        exec(cia_pkg::PFX_ED);
        exec(mop);
        chk_word({14'h0000, mode}, {14'h0000, emode}, "mode");
        exec(cia_pkg::OP_DIS);
        chk_word(16'(gap), 16'h0004, "disable length");
        chk_bit(en_a, 1'b0, "enable a after disable");
        chk_bit(en_b, 1'b0, "enable b after disable");
        raise_irq(v, 1'b0);
        exec(cia_pkg::OP_IDLE);
        exec(cia_pkg::OP_IDLE);
        chk_bit(got_ack, 1'b0, "accepted while disabled");
        exec(cia_pkg::OP_ENA);
        chk_bit(en_a, 1'b1, "enable a");
        chk_bit(en_b, 1'b1, "enable b");
        chk_bit(got_ack, 1'b0, "accepted during enable");
        exec(cia_pkg::OP_IDLE);
        chk_bit(got_ack, 1'b0, "accepted after enable");
        exec(cia_pkg::OP_IDLE);
        chk_bit(got_ack, 1'b1, "not accepted");
        chk_word(target, etgt, "target");
        chk_bit(got_tbl, etbl, "table read");
        chk_bit(en_a, 1'b0, "enable a after accept");
        chk_bit(en_b, 1'b0, "enable b after accept");
        $display("test irq mode %0d done", emode);
    endtask : irq_case

    task automatic halt_case;
        int n;
        exec(cia_pkg::OP_ENA);
        exec(cia_pkg::OP_IDLE);
        exec(cia_pkg::OP_HALT);
        opcode = cia_pkg::OP_IDLE;
        chk_bit(halted, 1'b1, "halted");
        n = 0;
        repeat (16) begin
            @(negedge clk);
            if (m1_end === 1'b1)
                n++;
        end
        chk_word(16'(n), 16'h0004, "idle cycles in halt");
        chk_bit(halted, 1'b1, "still halted");
        chk_word({8'h00, flags}, {8'h00, e_f}, "halt flags");
        raise_irq(8'h3C, 1'b1);
        n = 0;
        while (ack !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (ack !== 1'b1) begin
            fails++;
            $display("wrong value at %0t: halt never left", $time);
            end_sim();
        end
        @(negedge clk);
        chk_bit(halted, 1'b0, "halt exit");
        $display("test halt done");
    endtask : halt_case

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        chk_word(16'(mode), 16'(cia_pkg::MODE_ZERO), "reset mode");
        arith_case();
        idle_case();
        irq_case(cia_pkg::OP_MODE1, cia_pkg::MODE_ONE, 8'h12,
                 cia_pkg::RST_VECTOR, 1'b0);
        irq_case(cia_pkg::OP_MODE2, cia_pkg::MODE_TWO, 8'h7E,
                 {vec_base, 8'h7E}, 1'b1);
        irq_case(cia_pkg::OP_MODE0, cia_pkg::MODE_ZERO, 8'hC7,
                 {8'h00, 8'hC7}, 1'b0);
        halt_case();
        end_sim();
    end
endmodule : cia_core_tb_top
